// [bst_tap_ir.v]
// How it works
// - Controller advances only on scan clock rises
// - Shift-IR shifts instruction toward serial out
// - Capture-IR loads fixed value into instruction shifter
// - Update-DR falling edge latches data outputs
// - Exit1-IR: low to Pause, high to Update
// - Pause-IR holds; high goes to Exit2-IR
// - Exit2-IR: high to Update, low to Shift
// - Update-IR falling edge latches current instruction
// - Update-IR: low to Idle, high to Select-DR
// - Codes 000, 010 boundary; 001 identification
// - Codes 111, 011, 100 select bypass bit
// - Sample mode captures pins, shifts new data
// - Bypass passes data through one flip-flop
// - Extest drives outputs from boundary latches
// - Clamp holds outputs from boundary latches
// - Highz floats every pad output
// - Identification loaded at Capture-DR, shifted out
// - Reset state selects identification instruction
// - Identification: 1, maker, part, version
// - Identification: 32-bit shifter plus latch
// - Boundary cells have shifter and latch
`timescale 1ns/1ps
`default_nettype none
`include "bst_tap_map.vh"

module bst_tap_ir (
	input  wire                  clk_sys_i,
	input  wire                  nrst_i,
	input  wire                  scan_clock_pin_i,
	input  wire                  scan_mode_select_pin_i,
	input  wire                  scan_serial_in_pin_i,
	input  wire                  scan_reset_n_pin_i,
	output wire                  scan_serial_out_pin_o,
	output wire                  scan_serial_out_pin_oe_o,
	input  wire [`BST_PIN_N-1:0] pad_in_i,
	output wire [`BST_PIN_N-1:0] pad_out_o,
	output wire                  pad_oe_o,
	input  wire [`BST_PIN_N-1:0] core_out_i,
	input  wire                  core_oe_i,
	output wire [`BST_PIN_N-1:0] core_in_o
);

	localparam [15:0] S_TLR   = 16'h0001;
	localparam [15:0] S_RTI   = 16'h0002;
	localparam [15:0] S_SELDR = 16'h0004;
	localparam [15:0] S_CAPDR = 16'h0008;
	localparam [15:0] S_SHDR  = 16'h0010;
	localparam [15:0] S_EX1DR = 16'h0020;
	localparam [15:0] S_PSDR  = 16'h0040;
	localparam [15:0] S_EX2DR = 16'h0080;
	localparam [15:0] S_UPDR  = 16'h0100;
	localparam [15:0] S_SELIR = 16'h0200;
	localparam [15:0] S_CAPIR = 16'h0400;
	localparam [15:0] S_SHIR  = 16'h0800;
	localparam [15:0] S_EX1IR = 16'h1000;
	localparam [15:0] S_PSIR  = 16'h2000;
	localparam [15:0] S_EX2IR = 16'h4000;
	localparam [15:0] S_UPIR  = 16'h8000;

	localparam [1:0] SEL_BYP = 2'h0;
	localparam [1:0] SEL_ID  = 2'h1;
	localparam [1:0] SEL_BS  = 2'h2;

	localparam [`BST_ID_W-1:0] ID_VALUE = {`BST_ID_VERSION, `BST_ID_PART,
		`BST_ID_MAKER, `BST_ID_LSB};

	reg  [`BST_SYN_W-1:0]  syn1_ff;
	reg  [`BST_SYN_W-1:0]  syn2_ff;
	reg                    tck_d_ff;
	reg  [15:0]            st_ff;
	reg  [15:0]            nxt_st;
	reg  [`BST_IR_W-1:0]   ir_sh_ff;
	reg  [`BST_IR_W-1:0]   nxt_ir_sh;
	reg  [`BST_IR_W-1:0]   ir_ff;
	reg                    byp_ff;
	reg                    nxt_byp;
	reg  [`BST_ID_W-1:0]   id_sh_ff;
	reg  [`BST_ID_W-1:0]   nxt_id_sh;
	reg  [`BST_ID_W-1:0]   id_lat_ff;
	reg  [`BST_BS_W-1:0]   bs_sh_ff;
	reg  [`BST_BS_W-1:0]   nxt_bs_sh;
	reg  [`BST_BS_W-1:0]   bs_lat_ff;
	reg                    nxt_tdo;
	reg                    tdo_ff;
	reg                    tdo_oe_ff;
	reg  [`BST_PIN_N-1:0]  pad_out_ff;
	reg                    pad_oe_ff;
	reg  [`BST_PIN_N-1:0]  core_in_ff;
	wire                   tck_s;
	wire                   tms_s;
	wire                   tdi_s;
	wire                   trst_n_s;
	wire [`BST_PIN_N-1:0]  pad_s;
	wire                   tck_rise;
	wire                   tck_fall;
	wire                   rise;
	wire                   buf_in_rdy;
	wire                   buf_out_vld;
	wire [`BST_BUF_W-1:0]  buf_out;
	wire [1:0]             sel;
	wire                   drive_bs;

	// Instruction code to selected data register
	function [1:0] dr_sel;
		input [`BST_IR_W-1:0] code;
		begin
			case (code)
				`BST_IR_EXTEST: dr_sel = SEL_BS;
				`BST_IR_SAMPLE: dr_sel = SEL_BS;
				`BST_IR_IDCODE: dr_sel = SEL_ID;
				default:        dr_sel = SEL_BYP;
			endcase
		end
	endfunction

	assign tdi_s    = syn2_ff[`BST_SYN_TDI];
	assign tms_s    = syn2_ff[`BST_SYN_TMS];
	assign tck_s    = syn2_ff[`BST_SYN_TCK];
	assign trst_n_s = syn2_ff[`BST_SYN_TRST];
	assign pad_s    = syn2_ff[`BST_SYN_PAD_LO +: `BST_PIN_N];
	assign tck_rise = tck_s & ~tck_d_ff;
	assign tck_fall = ~tck_s & tck_d_ff;
	// A rise waits while the serial-out buffer is full
	assign rise     = tck_rise & buf_in_rdy;
	assign sel      = dr_sel(ir_ff);
	assign drive_bs = (ir_ff == `BST_IR_EXTEST) | (ir_ff == `BST_IR_CLAMP);

	always @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			syn1_ff  <= `BST_SYN_RST;
			syn2_ff  <= `BST_SYN_RST;
			tck_d_ff <= 1'b0;
		end else begin
			syn1_ff  <= {pad_in_i, scan_reset_n_pin_i, scan_clock_pin_i,
				scan_mode_select_pin_i, scan_serial_in_pin_i};
			syn2_ff  <= syn1_ff;
			// Edge tracker holds so a stalled rise is seen again
			if (!(tck_rise & ~buf_in_rdy))
				tck_d_ff <= tck_s;
		end
	end

	always @* begin
		nxt_st = S_TLR;
		case (st_ff)
			S_TLR:   nxt_st = tms_s ? S_TLR : S_RTI;
			S_RTI:   nxt_st = tms_s ? S_SELDR : S_RTI;
			S_SELDR: nxt_st = tms_s ? S_SELIR : S_CAPDR;
			S_CAPDR: nxt_st = tms_s ? S_EX1DR : S_SHDR;
			S_SHDR:  nxt_st = tms_s ? S_EX1DR : S_SHDR;
			S_EX1DR: nxt_st = tms_s ? S_UPDR : S_PSDR;
			S_PSDR:  nxt_st = tms_s ? S_EX2DR : S_PSDR;
			S_EX2DR: nxt_st = tms_s ? S_UPDR : S_SHDR;
			S_UPDR:  nxt_st = tms_s ? S_SELDR : S_RTI;
			S_SELIR: nxt_st = tms_s ? S_TLR : S_CAPIR;
			S_CAPIR: nxt_st = tms_s ? S_EX1IR : S_SHIR;
			S_SHIR:  nxt_st = tms_s ? S_EX1IR : S_SHIR;
			S_EX1IR: nxt_st = tms_s ? S_UPIR : S_PSIR;
			S_PSIR:  nxt_st = tms_s ? S_EX2IR : S_PSIR;
			S_EX2IR: nxt_st = tms_s ? S_UPIR : S_SHIR;
			S_UPIR:  nxt_st = tms_s ? S_SELDR : S_RTI;
			default: nxt_st = S_TLR;
		endcase
	end

	// Shift-stage next values for the current rise
	always @* begin
		nxt_ir_sh = ir_sh_ff;
		nxt_byp   = byp_ff;
		nxt_id_sh = id_sh_ff;
		nxt_bs_sh = bs_sh_ff;
		case (st_ff)
			S_CAPIR: nxt_ir_sh = `BST_IR_CAPTURE;
			S_SHIR:  nxt_ir_sh = {tdi_s, ir_sh_ff[`BST_IR_W-1:1]};
			S_CAPDR: begin
				nxt_byp   = 1'b0;
				nxt_id_sh = ID_VALUE;
				// Pins sampled without touching normal operation
				nxt_bs_sh = {core_oe_i, pad_s, core_out_i};
			end
			S_SHDR: begin
				case (sel)
					SEL_ID:  nxt_id_sh = {tdi_s, id_sh_ff[`BST_ID_W-1:1]};
					SEL_BS:  nxt_bs_sh = {tdi_s, bs_sh_ff[`BST_BS_W-1:1]};
					default: nxt_byp = tdi_s;
				endcase
			end
			default: nxt_ir_sh = ir_sh_ff;
		endcase
		if (nxt_st == S_SHIR)
			nxt_tdo = nxt_ir_sh[0];
		else if (sel == SEL_ID)
			nxt_tdo = nxt_id_sh[0];
		else if (sel == SEL_BS)
			nxt_tdo = nxt_bs_sh[0];
		else
			nxt_tdo = nxt_byp;
	end

	always @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_ff    <= S_TLR;
			ir_sh_ff <= `BST_IR_CAPTURE;
			byp_ff   <= 1'b0;
			id_sh_ff <= {`BST_ID_W{1'b0}};
			bs_sh_ff <= {`BST_BS_W{1'b0}};
		end else if (!trst_n_s) begin
			st_ff <= S_TLR;
		end else if (rise) begin
			st_ff    <= nxt_st;
			ir_sh_ff <= nxt_ir_sh;
			byp_ff   <= nxt_byp;
			id_sh_ff <= nxt_id_sh;
			bs_sh_ff <= nxt_bs_sh;
		end
	end

	// Update latches move on the falling scan clock edge; the reset state reloads the instruction at once
	always @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ir_ff     <= `BST_IR_IDCODE;
			id_lat_ff <= {`BST_ID_W{1'b0}};
			bs_lat_ff <= {`BST_BS_W{1'b0}};
		end else if (!trst_n_s || st_ff == S_TLR) begin
			ir_ff <= `BST_IR_IDCODE;
		end else if (tck_fall) begin
			if (st_ff == S_UPIR)
				ir_ff <= ir_sh_ff;
			if (st_ff == S_UPDR && sel == SEL_ID)
				id_lat_ff <= id_sh_ff;
			// Clamp keeps the latch frozen for the whole instruction
			if (st_ff == S_UPDR && sel == SEL_BS)
				bs_lat_ff <= bs_sh_ff;
		end
	end

	bst_buf2 #(
		.W(`BST_BUF_W)
	) i_bst_buf2 (
		.clk_sys_i   (clk_sys_i),
		.nrst_i      (nrst_i),
		.in_valid_i  (tck_rise),
		.in_ready_o  (buf_in_rdy),
		.in_data_i   ({(nxt_st == S_SHIR) | (nxt_st == S_SHDR), nxt_tdo}),
		.out_valid_o (buf_out_vld),
		.out_ready_i (tck_fall),
		.out_data_o  (buf_out)
	);

	// Serial out changes on the falling scan clock edge
	always @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tdo_ff    <= 1'b0;
			tdo_oe_ff <= 1'b0;
		end else if (!trst_n_s) begin
			tdo_oe_ff <= 1'b0;
		end else if (tck_fall && buf_out_vld) begin
			tdo_oe_ff <= buf_out[1];
			tdo_ff    <= buf_out[0];
		end
	end

	always @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pad_out_ff <= {`BST_PIN_N{1'b0}};
			pad_oe_ff  <= 1'b0;
			core_in_ff <= {`BST_PIN_N{1'b0}};
		end else begin
			core_in_ff <= pad_s;
			if (ir_ff == `BST_IR_HIGHZ) begin
				pad_out_ff <= core_out_i;
				pad_oe_ff  <= 1'b0;
			end else if (drive_bs) begin
				pad_out_ff <= bs_lat_ff[`BST_BS_OUT_LO +: `BST_PIN_N];
				pad_oe_ff  <= bs_lat_ff[`BST_BS_CTL];
			end else begin
				pad_out_ff <= core_out_i;
				pad_oe_ff  <= core_oe_i;
			end
		end
	end

	assign scan_serial_out_pin_o    = tdo_ff;
	assign scan_serial_out_pin_oe_o = tdo_oe_ff;
	assign pad_out_o                = pad_out_ff;
	assign pad_oe_o                 = pad_oe_ff;
	assign core_in_o                = core_in_ff;

endmodule // bst_tap_ir

`default_nettype wire

// [bst_tap_map.vh]
`ifndef BST_TAP_MAP_VH
`define BST_TAP_MAP_VH

// Instruction register
`define BST_IR_W          3
`define BST_IR_EXTEST     3'h0
`define BST_IR_IDCODE     3'h1
`define BST_IR_SAMPLE     3'h2
`define BST_IR_CLAMP      3'h3
`define BST_IR_HIGHZ      3'h4
`define BST_IR_BYPASS     3'h7
`define BST_IR_CAPTURE    3'h1

// Identification value fields, all values arbitrary
`define BST_ID_W          32
`define BST_ID_VERSION    4'h0
`define BST_ID_PART       16'h0ABC
`define BST_ID_MAKER      11'h055
`define BST_ID_LSB        1'h1

// Boundary cells: outputs low, inputs next, one control cell on top
`define BST_PIN_N         4
`define BST_BS_W          9
`define BST_BS_OUT_LO     0
`define BST_BS_IN_LO      4
`define BST_BS_CTL        8

// Pin synchroniser lanes
`define BST_SYN_W         8
`define BST_SYN_TDI       0
`define BST_SYN_TMS       1
`define BST_SYN_TCK       2
`define BST_SYN_TRST      3
`define BST_SYN_PAD_LO    4
`define BST_SYN_RST       8'h00

// Serial-out buffer word: {enable, bit}
`define BST_BUF_W         2

`endif

// [bst_buf2.v]
`timescale 1ns/1ps
`default_nettype none
`include "bst_tap_map.vh"

module bst_buf2 #(
	parameter W = `BST_BUF_W
) (
	input  wire         clk_sys_i,
	input  wire         nrst_i,
	input  wire         in_valid_i,
	output wire         in_ready_o,
	input  wire [W-1:0] in_data_i,
	output wire         out_valid_o,
	input  wire         out_ready_i,
	output wire [W-1:0] out_data_o
);

	reg [W-1:0] mem_ff [0:1];
	reg         wr_ff;
	reg         rd_ff;
	reg [1:0]   cnt_ff;
	wire        push;
	wire        pop;

	assign in_ready_o  = (cnt_ff != 2'h2);
	assign out_valid_o = (cnt_ff != 2'h0);
	assign out_data_o  = mem_ff[rd_ff];
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;

	always @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wr_ff     <= 1'b0;
			rd_ff     <= 1'b0;
			cnt_ff    <= 2'h0;
			mem_ff[0] <= {W{1'b0}};
			mem_ff[1] <= {W{1'b0}};
		end else begin
			if (push) begin
				mem_ff[wr_ff] <= in_data_i;
				wr_ff         <= ~wr_ff;
			end
			if (pop)
				rd_ff <= ~rd_ff;
			if (push & ~pop)
				cnt_ff <= cnt_ff + 2'h1;
			else if (pop & ~push)
				cnt_ff <= cnt_ff - 2'h1;
		end
	end

endmodule // bst_buf2

`default_nettype wire

// [bst_tap_ir_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
`include "bst_tap_map.vh"
module bst_tap_ir_checker (
	input wire logic                  clk_sys_i,
	input wire logic                  nrst_i,
	input wire logic                  scan_clock_pin_i,
	input wire logic                  scan_reset_n_pin_i,
	input wire logic                  scan_serial_out_pin_o,
	input wire logic                  scan_serial_out_pin_oe_o,
	input wire logic [`BST_PIN_N-1:0] pad_in_i,
	input wire logic [`BST_PIN_N-1:0] pad_out_o,
	input wire logic                  pad_oe_o,
	input wire logic [`BST_PIN_N-1:0] core_out_i,
	input wire logic                  core_oe_i,
	input wire logic [`BST_PIN_N-1:0] core_in_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);
	sequence s_trst_held;
		!scan_reset_n_pin_i [*6];
	endsequence
	// Scan reset excluded: it may drop the enable between clock edges
	sequence s_quiet;
		($stable(scan_clock_pin_i) && scan_reset_n_pin_i) [*8];
	endsequence
	property p_sdo_fall;
		$changed(scan_serial_out_pin_o) && scan_serial_out_pin_oe_o && scan_reset_n_pin_i
			|-> !$past(scan_clock_pin_i, 2);
	endproperty
	a_sdo_fall: assert property (p_sdo_fall) else $error("serial out moved off a fall");
	property p_oe_fall;
		$changed(scan_serial_out_pin_oe_o) && scan_reset_n_pin_i |-> !$past(scan_clock_pin_i, 2);
	endproperty
	a_oe_fall: assert property (p_oe_fall) else $error("serial enable moved off a fall");
	property p_hold;
		s_quiet |=> $stable(scan_serial_out_pin_o) && $stable(scan_serial_out_pin_oe_o);
	endproperty
	a_hold: assert property (p_hold) else $error("serial out moved with clock still");
	property p_trst_oe;
		s_trst_held |-> !scan_serial_out_pin_oe_o;
	endproperty
	a_trst_oe: assert property (p_trst_oe) else $error("serial out driven in reset");
	property p_trst_pads;
		s_trst_held |=> pad_out_o == $past(core_out_i) && pad_oe_o == $past(core_oe_i);
	endproperty
	a_trst_pads: assert property (p_trst_pads) else $error("pads not normal in reset");
	property p_core_in;
		$stable(pad_in_i) [*5] |-> core_in_o == pad_in_i;
	endproperty
	a_core_in: assert property (p_core_in) else $error("core input path broken");
	property p_rst_quiet;
		$rose(nrst_i) |-> !scan_serial_out_pin_oe_o && !pad_oe_o;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active at reset");
	property p_rst_pads;
		$rose(nrst_i) |=> pad_out_o == $past(core_out_i) && pad_oe_o == $past(core_oe_i);
	endproperty
	a_rst_pads: assert property (p_rst_pads) else $error("pads not normal after reset");
endmodule // bst_tap_ir_checker
bind bst_tap_ir bst_tap_ir_checker i_bst_tap_ir_checker (.clk_sys_i, .nrst_i, .scan_clock_pin_i,
	.scan_reset_n_pin_i, .scan_serial_out_pin_o, .scan_serial_out_pin_oe_o, .pad_in_i,
	.pad_out_o, .pad_oe_o, .core_out_i, .core_oe_i, .core_in_o);
`default_nettype wire

// [bst_scan_ctl_model.sv]
`timescale 1ns/1ps
`default_nettype none
module bst_scan_ctl_model (
	input  wire logic clk_sys_i,
	input  wire logic scan_serial_out_pin_i,
	output var  logic scan_clock_pin_o,
	output var  logic scan_mode_select_pin_o,
	output var  logic scan_serial_in_pin_o,
	output var  logic scan_reset_n_pin_o
);
	logic t;
	initial begin
		scan_clock_pin_o = 1'b0;
		scan_mode_select_pin_o = 1'b1;
		scan_serial_in_pin_o = 1'b0;
		scan_reset_n_pin_o = 1'b1;
	end
	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask
	// Serial out read late in high phase, after the design's sync delay
	task automatic tick(input logic tms, input logic tdi, output logic tdo);
		scan_mode_select_pin_o = tms;
		scan_serial_in_pin_o = tdi;
		wait_clk(4);
		scan_clock_pin_o = 1'b1;
		wait_clk(4);
		tdo = scan_serial_out_pin_i;
		scan_clock_pin_o = 1'b0;
	endtask
	task automatic scan(input logic ir, input int n, input logic [31:0] din,
			input logic pz, output logic [31:0] dout);
		dout = 32'h0;
		tick(1'b1, 1'b0, t);
		if (ir)
			tick(1'b1, 1'b0, t);
		tick(1'b0, 1'b0, t);
		tick(1'b0, 1'b0, t);
		for (int i = 0; i < n; i++) begin
			tick(i == n - 1 || (pz && i == 0), din[i], t);
			dout[i] = t;
			if (pz && i == 0) begin
				tick(1'b0, 1'b0, t);
				tick(1'b0, 1'b0, t);
				tick(1'b1, 1'b0, t);
				tick(1'b0, 1'b0, t);
			end
		end
		tick(1'b1, 1'b0, t);
		tick(1'b0, 1'b0, t);
	endtask
	task automatic test_reset();
		scan_reset_n_pin_o = 1'b0;
		wait_clk(8);
		scan_reset_n_pin_o = 1'b1;
		wait_clk(4);
		tick(1'b0, 1'b0, t);
	endtask
endmodule // bst_scan_ctl_model
`default_nettype wire

// [bst_tap_ir_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "bst_tap_map.vh"
module bst_tap_ir_tb;
	logic                  clk_sys_i;
	logic                  nrst_i;
	logic [`BST_PIN_N-1:0] pad_in_i;
	logic [`BST_PIN_N-1:0] core_out_i;
	logic                  core_oe_i;
	wire  [`BST_PIN_N-1:0] pad_out_o;
	wire  [`BST_PIN_N-1:0] core_in_o;
	wire                   pad_oe_o;
	wire                   sclk, smode, sdin, srst_n, sdout, sdout_oe;
	wire                   sdout_pin;
	// Released serial out shows the inverse of its last value
	assign sdout_pin = sdout_oe ? sdout : ~sdout;
	logic [31:0]           exp_q[$];
	logic [31:0]           res_q[$];
	logic [31:0]           v, w, r, e;
	logic [2:0]            code [3] = '{`BST_IR_BYPASS, `BST_IR_HIGHZ, `BST_IR_CLAMP};
	int                    fails = 0;
	int                    n_tests = 0;
	int                    cycles = 0;
	logic [31:0]           id_exp = {`BST_ID_VERSION, `BST_ID_PART, `BST_ID_MAKER, `BST_ID_LSB};
	bst_tap_ir i_bst_tap_ir (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .scan_clock_pin_i(sclk),
		.scan_mode_select_pin_i(smode), .scan_serial_in_pin_i(sdin),
		.scan_reset_n_pin_i(srst_n), .scan_serial_out_pin_o(sdout),
		.scan_serial_out_pin_oe_o(sdout_oe), .pad_in_i(pad_in_i), .pad_out_o(pad_out_o),
		.pad_oe_o(pad_oe_o), .core_out_i(core_out_i), .core_oe_i(core_oe_i),
		.core_in_o(core_in_o));
	bst_scan_ctl_model i_bst_scan_ctl_model (.clk_sys_i(clk_sys_i),
		.scan_serial_out_pin_i(sdout_pin), .scan_clock_pin_o(sclk),
		.scan_mode_select_pin_o(smode), .scan_serial_in_pin_o(sdin),
		.scan_reset_n_pin_o(srst_n));
	initial begin
		clk_sys_i = 1'b0;
		forever #20 clk_sys_i = ~clk_sys_i;
	end
	task automatic conclude();
		if (fails == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic scan_chk(input logic ir, input int n, input logic [31:0] din,
			input logic pz, input logic [31:0] ex);
		logic [31:0] got;
		exp_q.push_back(ex);
		i_bst_scan_ctl_model.scan(ir, n, din, pz, got);
		res_q.push_back(got);
	endtask
	// Floating pads compare as zero whatever value they hold
	task automatic pad_chk(input logic oe, input logic [3:0] val);
		exp_q.push_back(oe ? {27'h0, 1'b1, val} : 32'h0);
		i_bst_scan_ctl_model.wait_clk(3);
		res_q.push_back(pad_oe_o ? {27'h0, 1'b1, pad_out_o} : 32'h0);
	endtask
	always @(posedge clk_sys_i) begin
		while (res_q.size() > 0) begin
			r = res_q.pop_front();
			e = exp_q.pop_front();
			n_tests++;
			if (r !== e) begin
				fails++;
				$display("ERROR %0t: got %h expected %h", $time, r, e);
			end
		end
		cycles++;
		if (cycles == 8000) begin
			fails++;
			conclude();
		end
	end
	initial begin
		nrst_i = 1'b0;
		pad_in_i = 4'h5;
		core_out_i = 4'h3;
		core_oe_i = 1'b1;
		v = $urandom(32'hF55D);
		repeat (16) @(posedge clk_sys_i);
		#1 nrst_i = 1'b1;
		i_bst_scan_ctl_model.wait_clk(4);
		i_bst_scan_ctl_model.tick(1'b0, 1'b0, w);
		scan_chk(1'b0, 32, $urandom(), 1'b0, id_exp);
		scan_chk(1'b1, 3, `BST_IR_SAMPLE, 1'b1, `BST_IR_CAPTURE);
		pad_in_i = 4'($urandom());
		core_out_i = 4'($urandom());
		v = $urandom() | 32'h100;
		scan_chk(1'b0, 9, v, 1'b0, {core_oe_i, pad_in_i, core_out_i});
		pad_chk(core_oe_i, core_out_i);
		foreach (code[k]) begin
			scan_chk(1'b1, 3, code[k], 1'b0, `BST_IR_CAPTURE);
			w = $urandom();
			scan_chk(1'b0, 8, w, 1'b0, {w[6:0], 1'b0});
			core_out_i = 4'($urandom());
			if (k == 0)
				pad_chk(core_oe_i, core_out_i);
			if (k == 1)
				pad_chk(1'b0, 4'h0);
			if (k == 2)
				pad_chk(v[8], v[3:0]);
		end
		scan_chk(1'b1, 3, `BST_IR_EXTEST, 1'b0, `BST_IR_CAPTURE);
		pad_chk(v[8], v[3:0]);
		w = $urandom() | 32'h100;
		scan_chk(1'b0, 9, w, 1'b0, {core_oe_i, pad_in_i, core_out_i});
		pad_chk(1'b1, w[3:0]);
		scan_chk(1'b1, 3, `BST_IR_IDCODE, 1'b0, `BST_IR_CAPTURE);
		scan_chk(1'b0, 32, $urandom(), 1'b0, id_exp);
		// Scan clock stands still between frames
		i_bst_scan_ctl_model.wait_clk(12);
		i_bst_scan_ctl_model.test_reset();
		scan_chk(1'b0, 32, $urandom(), 1'b0, id_exp);
		pad_chk(core_oe_i, core_out_i);
		i_bst_scan_ctl_model.wait_clk(4);
		conclude();
	end
endmodule // bst_tap_ir_tb
`default_nettype wire
